// *** rtl/miwc_map.vh ***
// Register map, field positions and reset values of the interrupt and wake control
//
// Contract
// - Eleven sources: pin, timer, port, eight peripherals
// - Global enable passes unmasked requests, else blocks
// - Every reset clears the global enable
// - Return-from-interrupt sets the global enable
// - Service clears enable, pushes, loads vector
// - Pin and port events: three-four cycles
// - Flags set regardless of any enable
// - Enable cleared now blocks same-cycle service
// - Core register: three flags, enables, global
// - Peripheral flags and enables in own registers
// - Interrupt wake: next instruction, then vector
// - Resets load zero; wakes continue next address
// - Timeout and power-down bits encode cause
// - Power control: 10x at power-on, 1u0 brown-out
// - Pin edge chosen by edge-select bit
`ifndef MIWC_MAP_VH
`define MIWC_MAP_VH

// ************************************************************
// APB byte offsets
// ************************************************************
`define MIWC_OFS_CORE      8'h00
`define MIWC_OFS_PIE       8'h04
`define MIWC_OFS_PIR       8'h08
`define MIWC_OFS_OPTION    8'h0c
`define MIWC_OFS_STATUS    8'h10
`define MIWC_OFS_POWER_CONTROL_REG      8'h14
`define MIWC_OFS_ISTS      8'h18
`define MIWC_OFS_IMSK      8'h1c

// ************************************************************
// Core control register fields
// ************************************************************
`define MIWC_GIE           7
`define MIWC_PERIPH_GROUP_ENABLE          6
`define MIWC_T0IE          5
`define MIWC_EXTIE         4
`define MIWC_PCIE          3
`define MIWC_T0IF          2
`define MIWC_EXTIF         1
`define MIWC_PCIF          0

// Option register: edge select bit
`define MIWC_EDGE_BIT      0

// Status word: time-out and power-down bits
`define MIWC_TO_BIT        4
`define MIWC_PD_BIT        3

// Own interrupt status bits
`define MIWC_EV_VECTOR     0
`define MIWC_EV_WAKE       1
`define MIWC_EV_RESET      2

// ************************************************************
// Reset values and vectors
// ************************************************************
`define MIWC_CORE_RST      8'h00
`define MIWC_PERIPH_RST    8'h00
`define MIWC_OPTION_RST    8'h01
`define MIWC_POWER_CONTROL_REG_POR      3'h4
`define MIWC_RESET_VEC     13'h000
`define MIWC_IRQ_VEC       13'h004
// Edges until the pin synchronisers hold real samples
`define MIWC_SETTLE_CYC    2'h3

`endif

// *** rtl/miwc_sync_edge.v ***
// Two-stage synchroniser with a delayed copy for edge detection
`timescale 1ns/1ps
`default_nettype none

module miwc_sync_edge #(
    parameter W = 1
) (
    // Clock and reset
    input  wire         mclk_i,
    input  wire         rst_n_i,
    // Asynchronous input
    input  wire [W-1:0] async_i,
    // Synchronised level and its previous value
    output wire [W-1:0] sync_o,
    output wire [W-1:0] prev_o
);

    reg [W-1:0] meta_q;
    reg [W-1:0] sync_q;
    reg [W-1:0] prev_q;

    // Only sync_q reads meta_q
    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_q <= {W{1'b0}};
            sync_q <= {W{1'b0}};
            prev_q <= {W{1'b0}};
        end else begin
            meta_q <= async_i;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    assign sync_o = sync_q;
    assign prev_o = prev_q;

endmodule // miwc_sync_edge

`default_nettype wire

// *** rtl/miwc_top.v ***
// Interrupt, reset-vector and wake control with an APB register slave
`timescale 1ns/1ps
`default_nettype none
`include "miwc_map.vh"

module miwc_top #(
    parameter PORT_W = 6,
    parameter NPER   = 8
) (
    // Clock and reset
    input  wire              mclk_i,
    input  wire              rst_n_i,
    // APB slave
    input  wire              psel_i,
    input  wire              penable_i,
    input  wire              pwrite_i,
    input  wire [7:0]        paddr_i,
    input  wire [31:0]       pwdata_i,
    output wire [31:0]       prdata_o,
    output wire              pready_o,
    output wire              pslverr_o,
    // Interrupt sources
    input  wire              ext_irq_pin_i,
    input  wire [PORT_W-1:0] port_pins_i,
    input  wire              timer_zero_ovf_i,
    input  wire [NPER-1:0]   periph_evt_i,
    // Core sequencer
    input  wire              instr_end_i,
    input  wire              sleep_i,
    input  wire              return_from_irq_instr_i,
    input  wire              master_clear_rst_i,
    input  wire              watchdog_timer_rst_i,
    input  wire              brown_out_rst_i,
    input  wire              watchdog_timer_wake_i,
    output wire              core_irq_req_o,
    output wire              pc_load_o,
    output wire [12:0]       pc_value_o,
    output wire              stack_push_o,
    output wire              wake_o,
    // System interrupt
    output wire              irq_o
);

    // ************************************************************
    // State
    // ************************************************************
    reg  [7:0]      core_q;
    reg  [7:0]      core_d;
    reg  [NPER-1:0] pie_q;
    reg  [NPER-1:0] pie_d;
    reg  [NPER-1:0] pir_q;
    reg  [NPER-1:0] pir_d;
    reg  [7:0]      opt_q;
    reg  [7:0]      opt_d;
    reg             to_q;
    reg             to_d;
    reg             pd_q;
    reg             pd_d;
    reg  [2:0]      power_control_reg_q;
    reg  [2:0]      power_control_reg_d;
    reg  [2:0]      ists_q;
    reg  [2:0]      ists_d;
    reg  [2:0]      imsk_q;
    reg  [2:0]      imsk_d;
    reg  [31:0]     prdata_q;
    reg             pready_q;
    reg             pslverr_q;
    reg             req_q;
    reg             pc_load_q;
    reg  [12:0]     pc_val_q;
    reg             push_q;
    reg             wake_q;
    reg             irq_q;
    reg             sleep_q;

    // ************************************************************
    // Synchronised pins
    // ************************************************************
    wire              ext_s;
    wire              ext_p;
    wire [PORT_W-1:0] port_s;
    wire [PORT_W-1:0] port_p;

    // External interrupt pin
    miwc_sync_edge #(.W(1)) u_ext_sync (
        .mclk_i  (mclk_i),
        .rst_n_i (rst_n_i),
        .async_i (ext_irq_pin_i),
        .sync_o  (ext_s),
        .prev_o  (ext_p)
    );

    // Port change pins
    miwc_sync_edge #(.W(PORT_W)) u_port_sync (
        .mclk_i  (mclk_i),
        .rst_n_i (rst_n_i),
        .async_i (port_pins_i),
        .sync_o  (port_s),
        .prev_o  (port_p)
    );

    // ************************************************************
    // Pin settle after reset
    // ************************************************************
    reg  [1:0]        settle_q;

    // Counts edges until both synchroniser stages and the delayed copy hold pin samples
    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            settle_q <= 2'h0;
        end else if (settle_q != `MIWC_SETTLE_CYC) begin
            settle_q <= settle_q + 2'h1;
        end
    end

    // A pin idling high would otherwise look like an edge after reset
    wire pins_live = (settle_q == `MIWC_SETTLE_CYC);

    // ************************************************************
    // Source events
    // ************************************************************
    wire ext_sel  = opt_q[`MIWC_EDGE_BIT];
    // Rising edge when select is one, falling when zero
    wire ext_evt  = pins_live
                  & (ext_sel ? (ext_s & ~ext_p) : (~ext_s & ext_p));
    wire port_evt = pins_live & |(port_s ^ port_p);

    // ************************************************************
    // APB decode
    // ************************************************************
    // Setup phase, and the access edge that lands a write
    wire setup  = psel_i & ~penable_i;
    wire commit = psel_i & penable_i & pready_q;
    wire wr     = commit & pwrite_i & ~pslverr_q;

    // One write strobe per writable word
    wire wr_core = wr & (paddr_i == `MIWC_OFS_CORE);
    wire wr_pie  = wr & (paddr_i == `MIWC_OFS_PIE);
    wire wr_pir  = wr & (paddr_i == `MIWC_OFS_PIR);
    wire wr_opt  = wr & (paddr_i == `MIWC_OFS_OPTION);
    wire wr_power_control_reg = wr & (paddr_i == `MIWC_OFS_POWER_CONTROL_REG);
    wire wr_ists = wr & (paddr_i == `MIWC_OFS_ISTS);
    wire wr_imsk = wr & (paddr_i == `MIWC_OFS_IMSK);

    // Address is one of the eight words
    function mapped;
        input [7:0] a;
        begin
            mapped = (a[1:0] == 2'b00) && (a <= `MIWC_OFS_IMSK);
        end
    endfunction

    // Requests from flag and enable pairs, global enable excluded
    function pend_of;
        input [7:0]      c;
        input [NPER-1:0] f;
        input [NPER-1:0] e;
        begin
            pend_of = (c[`MIWC_T0IF] & c[`MIWC_T0IE])
                    | (c[`MIWC_EXTIF] & c[`MIWC_EXTIE])
                    | (c[`MIWC_PCIF] & c[`MIWC_PCIE])
                    | (c[`MIWC_PERIPH_GROUP_ENABLE] & |(f & e));
        end
    endfunction

    // ************************************************************
    // Request, service and wake
    // ************************************************************
    wire pend     = pend_of(core_q, pir_q, pie_q);
    // A write that clears the global enable blocks this cycle's service
    wire gie_eff  = core_q[`MIWC_GIE]
                  & ~(wr_core & ~pwdata_i[`MIWC_GIE]);
    wire req      = gie_eff & pend;
    // Service only at an instruction boundary while awake
    wire take     = instr_end_i & ~sleep_i & req;
    // Enabled request wakes regardless of global enable
    wire int_wake = sleep_i & pend & ~wake_q;
    wire any_rst  = master_clear_rst_i | watchdog_timer_rst_i
                  | brown_out_rst_i;
    // Watchdog wake counts only while the core sleeps
    wire wdt_wake = watchdog_timer_wake_i & sleep_i;

    // ************************************************************
    // Register next values
    // ************************************************************
    always @* begin
        // Bus writes first, events and resets override below
        core_d = wr_core ? pwdata_i[7:0] : core_q;
        pie_d  = wr_pie ? pwdata_i[NPER-1:0] : pie_q;
        pir_d  = wr_pir ? pwdata_i[NPER-1:0] : pir_q;
        opt_d  = wr_opt ? pwdata_i[7:0] : opt_q;
        power_control_reg_d = wr_power_control_reg ? {power_control_reg_q[2], pwdata_i[1:0]} : power_control_reg_q;
        imsk_d = wr_imsk ? pwdata_i[2:0] : imsk_q;
        ists_d = wr_ists ? (ists_q & ~pwdata_i[2:0]) : ists_q;
        // Status bits move only on wake or reset
        to_d   = to_q;
        pd_d   = pd_q;
        // Service clears the global enable
        if (take) begin
            core_d[`MIWC_GIE] = 1'b0;
        end
        // Return from interrupt wins over service
        if (return_from_irq_instr_i) begin
            core_d[`MIWC_GIE] = 1'b1;
        end
        // Flags set independent of enables, set beats clear
        core_d[`MIWC_T0IF]  = core_d[`MIWC_T0IF] | timer_zero_ovf_i;
        core_d[`MIWC_EXTIF] = core_d[`MIWC_EXTIF] | ext_evt;
        core_d[`MIWC_PCIF]  = core_d[`MIWC_PCIF] | port_evt;
        pir_d = pir_d | periph_evt_i;
        // Wake causes
        if (wdt_wake) begin
            to_d = 1'b0;
            pd_d = 1'b0;
        end else if (int_wake) begin
            to_d = 1'b1;
            pd_d = 1'b0;
        end
        // Event status, set beats clear
        ists_d[`MIWC_EV_VECTOR] = ists_d[`MIWC_EV_VECTOR] | take;
        ists_d[`MIWC_EV_WAKE]   = ists_d[`MIWC_EV_WAKE] | int_wake
                                | wdt_wake;
        ists_d[`MIWC_EV_RESET]  = ists_d[`MIWC_EV_RESET] | any_rst;
        // Resets from the core load the core, peripheral and option registers with their reset values
        if (any_rst) begin
            core_d = `MIWC_CORE_RST;
            pie_d  = `MIWC_PERIPH_RST;
            pir_d  = `MIWC_PERIPH_RST;
            opt_d  = `MIWC_OPTION_RST;
        end
        if (brown_out_rst_i) begin
            to_d      = 1'b1;
            pd_d      = 1'b1;
            power_control_reg_d[0] = 1'b0;
        end else if (watchdog_timer_rst_i) begin
            to_d = 1'b0;
        end else if (master_clear_rst_i & sleep_q) begin
            to_d = 1'b1;
            pd_d = 1'b0;
        end
    end

    // Request as it stands after this edge, so it drops with service
    wire req_nxt = core_d[`MIWC_GIE] & pend_of(core_d, pir_d, pie_d);

    // ************************************************************
    // Control registers
    // ************************************************************
    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            core_q <= `MIWC_CORE_RST;
            pie_q  <= `MIWC_PERIPH_RST;
            pir_q  <= `MIWC_PERIPH_RST;
            opt_q  <= `MIWC_OPTION_RST;
            to_q   <= 1'b1;
            pd_q   <= 1'b1;
            power_control_reg_q <= `MIWC_POWER_CONTROL_REG_POR;
            ists_q <= 3'h0;
            imsk_q <= 3'h0;
        end else begin
            core_q <= core_d;
            pie_q  <= pie_d;
            pir_q  <= pir_d;
            opt_q  <= opt_d;
            to_q   <= to_d;
            pd_q   <= pd_d;
            power_control_reg_q <= power_control_reg_d;
            ists_q <= ists_d;
            imsk_q <= imsk_d;
        end
    end

    // ************************************************************
    // Core sequencer outputs
    // ************************************************************
    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pc_load_q <= 1'b1;
            pc_val_q  <= `MIWC_RESET_VEC;
            push_q    <= 1'b0;
            wake_q    <= 1'b0;
            req_q     <= 1'b0;
            sleep_q   <= 1'b0;
            irq_q     <= 1'b0;
        end else begin
            sleep_q <= sleep_i;
            req_q   <= req_nxt;
            wake_q  <= int_wake | wdt_wake;
            push_q  <= take & ~any_rst;
            irq_q   <= |(ists_d & imsk_d);
            // Core resets outrank service
            if (any_rst) begin
                pc_load_q <= 1'b1;
                pc_val_q  <= `MIWC_RESET_VEC;
            end else if (take) begin
                pc_load_q <= 1'b1;
                pc_val_q  <= `MIWC_IRQ_VEC;
            end else begin
                pc_load_q <= 1'b0;
            end
        end
    end

    // ************************************************************
    // APB read and answer
    // ************************************************************
    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0;
        end else begin
            // Answer one cycle after every setup
            pready_q  <= setup;
            pslverr_q <= setup & ~mapped(paddr_i);
            // Read word taken at setup, held to the next one
            if (setup) begin
                case (paddr_i)
                    `MIWC_OFS_CORE:   prdata_q <= {24'h0, core_q};
                    `MIWC_OFS_PIE:    prdata_q <= {{(32-NPER){1'b0}}, pie_q};
                    `MIWC_OFS_PIR:    prdata_q <= {{(32-NPER){1'b0}}, pir_q};
                    `MIWC_OFS_OPTION: prdata_q <= {24'h0, opt_q};
                    `MIWC_OFS_STATUS: prdata_q <= {27'h0, to_q, pd_q, 3'h0};
                    `MIWC_OFS_POWER_CONTROL_REG:   prdata_q <= {29'h0, power_control_reg_q};
                    `MIWC_OFS_ISTS:   prdata_q <= {29'h0, ists_q};
                    `MIWC_OFS_IMSK:   prdata_q <= {29'h0, imsk_q};
                    default:          prdata_q <= 32'h0;
                endcase
            end
        end
    end

    // Outputs straight from flip-flops
    assign prdata_o       = prdata_q;
    assign pready_o       = pready_q;
    assign pslverr_o      = pslverr_q;
    assign core_irq_req_o = req_q;
    assign pc_load_o      = pc_load_q;
    assign pc_value_o     = pc_val_q;
    assign stack_push_o   = push_q;
    assign wake_o         = wake_q;
    assign irq_o          = irq_q;

endmodule // miwc_top

`default_nettype wire

// *** tb/miwc_asserts.sv ***
// Concurrent checks on the ports of the interrupt and wake control
`timescale 1ns/1ps
`default_nettype none
module miwc_asserts (
    // Clock, reset and bus
    input wire logic        mclk_i,
    input wire logic        rst_n_i,
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        pwrite_i,
    input wire logic        pready_o,
    // Core sequencer
    input wire logic        instr_end_i,
    input wire logic        sleep_i,
    input wire logic        master_clear_rst_i,
    input wire logic        watchdog_timer_rst_i,
    input wire logic        brown_out_rst_i,
    input wire logic        core_irq_req_o,
    input wire logic        pc_load_o,
    input wire logic [12:0] pc_value_o,
    input wire logic        stack_push_o,
    input wire logic        wake_o
);
    // ************************************************************
    // Properties
    // ************************************************************
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    // A push always comes with the fixed vector
    property p_vec; stack_push_o |-> pc_load_o && pc_value_o == 13'h004; endproperty
    a_vec: assert property (p_vec) else $error("push without vector load");
    // Awake boundary with a request is serviced unless a write races it
    property p_svc; core_irq_req_o && instr_end_i && !sleep_i && !(psel_i && pwrite_i) |=> stack_push_o; endproperty
    a_svc: assert property (p_svc) else $error("request not serviced");
    // Service only at an awake boundary with a request
    property p_cause; stack_push_o |-> $past(instr_end_i && core_irq_req_o && !sleep_i); endproperty
    a_cause: assert property (p_cause) else $error("push without cause");
    // Global enable is gone after service
    property p_gie; stack_push_o |=> !core_irq_req_o; endproperty
    a_gie: assert property (p_gie) else $error("request after service");
    // Wake only out of sleep
    property p_wake; wake_o |-> $past(sleep_i); endproperty
    a_wake: assert property (p_wake) else $error("wake while awake");
    // Setup is answered in the next cycle
    property p_rdy; psel_i && !penable_i |=> pready_o; endproperty
    a_rdy: assert property (p_rdy) else $error("no ready after setup");
    // Ready lasts one cycle
    property p_rdy1; pready_o |=> !pready_o; endproperty
    a_rdy1: assert property (p_rdy1) else $error("ready too long");
    // Core resets load address zero without a push
    property p_rst; master_clear_rst_i || watchdog_timer_rst_i || brown_out_rst_i
        |=> pc_load_o && pc_value_o == 13'h000 && !stack_push_o; endproperty
    a_rst: assert property (p_rst) else $error("reset vector missing");
    // Counter load is a single pulse
    property p_pcl; pc_load_o |=> !pc_load_o; endproperty
    a_pcl: assert property (p_pcl) else $error("load held");
endmodule // miwc_asserts
bind miwc_top miwc_asserts i_chk (.*);
`default_nettype wire

// *** tb/miwc_core_model.sv ***
// Behavioural core sequencer: instruction boundaries and sleep
`timescale 1ns/1ps
`default_nettype none
module miwc_core_model #(
    parameter GAP = 4
) (
    // Clock and reset
    input wire logic  mclk_i,
    input wire logic  rst_n_i,
    // Bench commands and wake from the block
    input wire logic  run_i,
    input wire logic  nap_i,
    input wire logic  wake_i,
    // Sequencer outputs
    output var logic  instr_end_o,
    output var logic  sleep_o
);
    logic [3:0] cnt_q;
    // Boundaries every GAP cycles while awake and run_i is high; wake resumes at next instruction
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_q <= 4'h0;
            instr_end_o <= 1'h0;
            sleep_o <= 1'h0;
        end else begin
            if (nap_i) sleep_o <= 1'h1;
            else if (wake_i) sleep_o <= 1'h0;
            instr_end_o <= 1'h0;
            if (sleep_o || !run_i) cnt_q <= 4'h0;
            else if (cnt_q == 4'(GAP - 1)) begin
                cnt_q <= 4'h0;
                instr_end_o <= 1'h1;
            end else cnt_q <= cnt_q + 4'h1;
        end
    end
endmodule // miwc_core_model
`default_nettype wire

// *** tb/tb.sv ***
// Self-checking bench of the interrupt and wake control
`timescale 1ns/1ps
`default_nettype none
module tb;
    // ************************************************************
    // Signals and instances
    // ************************************************************
    logic        mclk_i = 1'h0, rst_n_i = 1'h0, psel_i = 1'h0, penable_i = 1'h0, pwrite_i = 1'h0;
    logic [7:0]  paddr_i = 8'h00, periph_evt_i = 8'h00;
    logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
    logic [5:0]  port_pins_i = 6'h00;
    logic [2:0]  rst3 = 3'h0;
    logic [12:0] pc_value_o;
    logic        ext_irq_pin_i = 1'h0, timer_zero_ovf_i = 1'h0, return_from_irq_instr_i = 1'h0;
    logic        watchdog_timer_wake_i = 1'h0, run = 1'h0, nap = 1'h0, er;
    logic        pready_o, pslverr_o, core_irq_req_o, pc_load_o, stack_push_o, wake_o, irq_o, instr_end_i, sleep_i;
    wire         master_clear_rst_i = rst3[2];
    wire         watchdog_timer_rst_i = rst3[1];
    wire         brown_out_rst_i = rst3[0];
    int          fail_count = 0, total_checks = 0, cyc = 0, i, k;
    // Rows: address, reset value, write value, read-back, error
    logic [39:0] tbl [7] = '{40'h0000787800, 40'h0400ffff00, 40'h0800000000, 40'h0c01000000,
                             40'h1018001800, 40'h1404030700, 40'h2000ff0001};
    // Rows: reset select, status, power control
    logic [23:0] rs [3] = '{24'h011806, 24'h020806, 24'h040806};
    miwc_top i_dut (.*);
    miwc_core_model i_core (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .run_i(run), .nap_i(nap), .wake_i(wake_o),
                            .instr_end_o(instr_end_i), .sleep_o(sleep_i));
    // Clock and hang guard
    always #20 mclk_i = ~mclk_i;
    always @(posedge mclk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count++;
            complete_run;
        end
    end
    // ************************************************************
    // Tasks
    // ************************************************************
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk_i);
        psel_i <= 1'h1;
        penable_i <= 1'h0;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge mclk_i);
        penable_i <= 1'h1;
        @(posedge mclk_i);
        while (pready_o !== 1'h1) @(posedge mclk_i);
        rd = prdata_o;
        er = pslverr_o;
        psel_i <= 1'h0;
        penable_i <= 1'h0;
    endtask
    task rc(input string n, input logic [7:0] a, input logic [7:0] e);
        apb(1'h0, a, 32'h0);
        chk(n, {24'h0, e}, rd);
    endtask
    task tz;
        @(posedge mclk_i);
        timer_zero_ovf_i <= 1'h1;
        @(posedge mclk_i);
        timer_zero_ovf_i <= 1'h0;
    endtask
    task wfor(input logic s);
        k = 0;
        while (((s ? wake_o : stack_push_o) !== 1'h1) && k < 60) begin
            @(negedge mclk_i);
            k++;
        end
        chk(s ? "wake" : "push", 32'h1, {31'h0, s ? wake_o : stack_push_o});
        if (!s) chk("vector", 32'h4, {19'h0, pc_value_o});
    endtask
    task complete_run;
        if (fail_count == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // ************************************************************
    // Sequence
    // ************************************************************
    initial begin
        repeat (6) @(posedge mclk_i);
        rst_n_i <= 1'h1;
        // Reset values, access kinds, unmapped address
        for (i = 0; i < 7; i++) begin
            rc("reset value", tbl[i][39:32], tbl[i][31:24]);
            chk("error", {31'h0, tbl[i][0]}, {31'h0, er});
            apb(1'h1, tbl[i][39:32], {24'h0, tbl[i][23:16]});
            rc("read back", tbl[i][39:32], tbl[i][15:8]);
            apb(1'h1, tbl[i][39:32], {24'h0, tbl[i][31:24]});
        end
        // Flags set with every enable off, then gating of the request
        periph_evt_i <= 8'hff;
        tz;
        periph_evt_i <= 8'h00;
        rc("periph flags", 8'h08, 8'hff);
        rc("core flags", 8'h00, 8'h04);
        apb(1'h1, 8'h00, 32'h84);
        apb(1'h1, 8'h04, 32'h01);
        repeat (2) @(negedge mclk_i);
        chk("req group off", 32'h0, {31'h0, core_irq_req_o});
        apb(1'h1, 8'h00, 32'hc4);
        repeat (2) @(negedge mclk_i);
        chk("req group on", 32'h1, {31'h0, core_irq_req_o});
        apb(1'h1, 8'h00, 32'h44);
        repeat (2) @(negedge mclk_i);
        chk("req global off", 32'h0, {31'h0, core_irq_req_o});
        apb(1'h1, 8'h08, 32'h0);
        apb(1'h1, 8'h04, 32'h0);
        // Service, then return sets the global enable
        apb(1'h1, 8'h00, 32'ha4);
        run <= 1'h1;
        wfor(1'h0);
        run <= 1'h0;
        rc("after service", 8'h00, 8'h24);
        @(posedge mclk_i);
        return_from_irq_instr_i <= 1'h1;
        @(posedge mclk_i);
        return_from_irq_instr_i <= 1'h0;
        rc("after return", 8'h00, 8'ha4);
        apb(1'h1, 8'h00, 32'h0);
        // Level interrupt: raise, mask, clear
        apb(1'h1, 8'h1c, 32'h1);
        repeat (2) @(negedge mclk_i);
        chk("irq raised", 32'h1, {31'h0, irq_o});
        apb(1'h1, 8'h1c, 32'h0);
        repeat (2) @(negedge mclk_i);
        chk("irq masked", 32'h0, {31'h0, irq_o});
        apb(1'h1, 8'h1c, 32'h1);
        apb(1'h1, 8'h18, 32'hff);
        repeat (2) @(negedge mclk_i);
        chk("irq cleared", 32'h0, {31'h0, irq_o});
        // Pin edge select, wrong edge first
        for (i = 0; i < 2; i++) begin
            ext_irq_pin_i <= i[0];
            apb(1'h1, 8'h0c, i);
            apb(1'h1, 8'h00, 32'h0);
            ext_irq_pin_i <= !i[0];
            repeat (6) @(posedge mclk_i);
            rc("wrong edge", 8'h00, 8'h00);
            ext_irq_pin_i <= i[0];
            repeat (6) @(posedge mclk_i);
            rc("right edge", 8'h00, 8'h02);
        end
        port_pins_i <= 6'h20;
        repeat (6) @(posedge mclk_i);
        rc("port change", 8'h00, 8'h03);
        // Pin latency with the core running
        apb(1'h1, 8'h00, 32'h90);
        run <= 1'h1;
        apb(1'h1, 8'h0c, 32'h0);
        ext_irq_pin_i <= 1'h0;
        wfor(1'h0);
        chk("latency", 32'h1, {31'h0, k <= 18});
        run <= 1'h0;
        // Wake without and with the global enable
        apb(1'h1, 8'h00, 32'h20);
        for (i = 0; i < 2; i++) begin
            @(posedge mclk_i);
            nap <= 1'h1;
            @(posedge mclk_i);
            nap <= 1'h0;
            tz;
            wfor(1'h1);
            rc("wake status", 8'h10, 8'h10);
            if (i == 0) begin
                rc("no vector", 8'h00, 8'h24);
                apb(1'h1, 8'h00, 32'ha0);
            end
        end
        run <= 1'h1;
        wfor(1'h0);
        run <= 1'h0;
        // Core resets: brown-out, watchdog, master clear awake
        apb(1'h1, 8'h14, 32'h07);
        for (i = 0; i < 3; i++) begin
            apb(1'h1, 8'h00, 32'h80);
            @(posedge mclk_i);
            rst3 <= rs[i][18:16];
            @(posedge mclk_i);
            rst3 <= 3'h0;
            rc("core", 8'h00, 8'h00);
            rc("status", 8'h10, rs[i][15:8]);
            rc("power", 8'h14, rs[i][7:0]);
            rc("option", 8'h0c, 8'h01);
        end
        complete_run;
    end
endmodule // tb
`default_nettype wire
